// ==== verilog/battery_status_flag_logic.sv ====
// Purpose: alarm, status, error and pack status flags of a gas gauge
// Assumes: measurements arrive with a one-cycle update strobe
// Notes:   capacity mode selects current or power figures for alarms
`timescale 1ns/1ns

// Behaviour
// - terminate-charge set on termination, clear when idle
// - over-temp set at charge/discharge threshold
// - over-temp clears below matching reset level
// - terminate-discharge set on empty/low conditions
// - terminate-discharge clears when all conditions good
// - capacity alarm follows host level comparison
// - time alarm follows host time comparison
// - initialized tracks valid configuration load
// - discharging set unless charging detected
// - fully-charged set on termination, clear below percent
// - fully-discharged set below level2, clear at 20%
// - ok code after error-free command
// - busy code when command cannot run
// - reserved code for reserved command access
// - error code for unsupported manufacturer command
// - cycle count saturates at 65535
// - level2 pack flag follows voltage comparison
// - seal state shown in pack flag
// - front-end fail flag shows comm failure
// - discharge-qualified flag shown in pack status
// - permanent failure follows stored byte
// - unlatched protection fault flags
// - status word returned for command 0x16
// - alarms use current or power per mode
module battery_status_flag_logic
  import batt_flags_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // measurement update
  input  wire logic        update_in,
  input  wire logic        capacity_mode_in,
  input  wire logic [15:0] voltage_in,
  input  wire logic [15:0] cell_voltage_in,
  input  wire logic        use_cell_voltage_in,
  input  wire logic [15:0] current_in,
  input  wire logic        charging_in,
  input  wire logic [15:0] temperature_in,
  input  wire logic [15:0] remaining_capacity_ma_in,
  input  wire logic [15:0] remaining_capacity_mw_in,
  input  wire logic [15:0] time_to_empty_ma_in,
  input  wire logic [15:0] time_to_empty_mw_in,
  input  wire logic [7:0]  relative_soc_in,
  input  wire logic        charge_term_in,
  input  wire logic        overcharge_in,
  // thresholds
  input  wire logic [15:0] ot_charge_in,
  input  wire logic [15:0] ot_charge_reset_in,
  input  wire logic [15:0] ot_dsg_in,
  input  wire logic [15:0] ot_dsg_reset_in,
  input  wire logic [15:0] terminate_voltage_in,
  input  wire logic [15:0] suspend_temp_low_in,
  input  wire logic [15:0] cap_alarm_in,
  input  wire logic [15:0] time_alarm_in,
  input  wire logic [15:0] end_of_discharge_level2_in,
  input  wire logic [15:0] overload_current_in,
  input  wire logic [7:0]  full_clear_pct_in,
  input  wire logic [7:0]  battery_low_pct_in,
  // configuration and protection
  input  wire logic        config_valid_in,
  input  wire logic        config_bad_in,
  input  wire logic        sealed_in,
  input  wire logic        front_end_fail_in,
  input  wire logic        discharge_ok_in,
  input  wire logic [7:0]  perm_fail_byte_in,
  input  wire logic        sec_prot_fault_in,
  input  wire logic        cell_uv_fault_in,
  input  wire logic        cycle_inc_in,
  // command handling
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic        cmd_busy_in,
  input  wire logic        cmd_reserved_in,
  input  wire logic        cmd_unsupported_in,
  // outputs
  output logic      [15:0] battery_status_out,
  output logic      [15:0] pack_status_out,
  output logic      [15:0] cycle_count_out,
  output logic      [15:0] read_data_out,
  output logic             read_valid_out
);

  // ---------------------------------------------------------------
  // mode selection
  // ---------------------------------------------------------------
  wire logic [15:0] rem_cap;
  wire logic [15:0] tte;
  assign rem_cap = capacity_mode_in ? remaining_capacity_mw_in
                                    : remaining_capacity_ma_in;
  assign tte     = capacity_mode_in ? time_to_empty_mw_in
                                    : time_to_empty_ma_in;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic        term_chg_reg, over_temp_reg, term_dsg_reg;
  logic        rem_cap_reg, rem_time_reg, init_reg, dsg_reg;
  logic        full_chg_reg, full_dsg_reg, perm_fail_reg, eod2_reg;
  logic [3:0]  err_reg;
  logic [15:0] cycle_reg, prev_cap_reg, prev_tte_reg;
  logic        term_chg_next, over_temp_next, term_dsg_next;
  logic        rem_cap_next, rem_time_next, init_next, dsg_next;
  logic        full_chg_next, full_dsg_next, perm_fail_next, eod2_next;
  logic [3:0]  err_next;
  logic [15:0] cycle_next;

  // ---------------------------------------------------------------
  // flag conditions
  // ---------------------------------------------------------------
  wire logic [15:0] eod_v;
  wire logic        ot_set, ot_clr, td_set, td_clr;
  wire logic        rc_set, rc_clr, rt_set, rt_clr;
  wire logic        fd_set, fd_clr;
  assign eod_v  = use_cell_voltage_in ? cell_voltage_in : voltage_in;
  assign ot_set = charging_in ? (temperature_in >= ot_charge_in)
                              : (temperature_in >= ot_dsg_in);
  assign ot_clr = charging_in ? (temperature_in < ot_charge_reset_in)
                              : (temperature_in < ot_dsg_reset_in);
  assign td_set = (rem_cap == 16'h0000) ||
                  (voltage_in == terminate_voltage_in) ||
                  (temperature_in <= suspend_temp_low_in) ||
                  cell_uv_fault_in;
  assign td_clr = (voltage_in > terminate_voltage_in) &&
                  (rem_cap > 16'h0000) && !cell_uv_fault_in;
  assign rc_set = rem_cap < cap_alarm_in;
  assign rc_clr = (cap_alarm_in < rem_cap) ||
                  (charging_in && rem_cap > prev_cap_reg);
  assign rt_set = !charging_in && (tte < time_alarm_in);
  assign rt_clr = (time_alarm_in < tte) ||
                  (charging_in && tte > prev_tte_reg);
  assign fd_set = ((eod_v < end_of_discharge_level2_in) &&
                   (current_in < overload_current_in)) ||
                  (relative_soc_in < battery_low_pct_in);
  assign fd_clr = relative_soc_in >= FULL_DSG_CLR;

  // ---------------------------------------------------------------
  // next state, evaluated on each update
  // ---------------------------------------------------------------
  always_comb begin
    term_chg_next  = term_chg_reg;
    over_temp_next = over_temp_reg;
    term_dsg_next  = term_dsg_reg;
    rem_cap_next   = rem_cap_reg;
    rem_time_next  = rem_time_reg;
    dsg_next       = dsg_reg;
    full_chg_next  = full_chg_reg;
    full_dsg_next  = full_dsg_reg;
    eod2_next      = eod2_reg;
    if (update_in) begin
      if (charge_term_in) begin
        term_chg_next = 1'b1;
      end else if (!charging_in) begin
        term_chg_next = 1'b0;
      end
      if (ot_set) begin
        over_temp_next = 1'b1;
      end else if (ot_clr) begin
        over_temp_next = 1'b0;
      end
      if (td_set) begin
        term_dsg_next = 1'b1;
      end else if (td_clr) begin
        term_dsg_next = 1'b0;
      end
      if (rc_set) begin
        rem_cap_next = 1'b1;
      end else if (rc_clr) begin
        rem_cap_next = 1'b0;
      end
      if (rt_set) begin
        rem_time_next = 1'b1;
      end else if (rt_clr) begin
        rem_time_next = 1'b0;
      end
      dsg_next = !charging_in;
      if (charge_term_in || overcharge_in) begin
        full_chg_next = 1'b1;
      end else if (relative_soc_in < full_clear_pct_in) begin
        full_chg_next = 1'b0;
      end
      if (fd_set) begin
        full_dsg_next = 1'b1;
      end else if (fd_clr) begin
        full_dsg_next = 1'b0;
      end
      eod2_next = eod_v <= end_of_discharge_level2_in;
    end
  end

  // configuration load, set wins
  assign init_next = config_valid_in ? 1'b1
                   : (config_bad_in ? 1'b0 : init_reg);

  // permanent failure byte tracking
  assign perm_fail_next = (perm_fail_byte_in == PERM_FAIL_SET_CODE) ? 1'b1
                        : (perm_fail_byte_in == PERM_FAIL_CLR_CODE) ? 1'b0
                        : perm_fail_reg;

  // saturating cycle counter
  assign cycle_next = (cycle_inc_in && cycle_reg != CYCLE_MAX)
                    ? cycle_reg + 16'h0001 : cycle_reg;

  // command result, priority busy, reserved, unsupported
  always_comb begin
    err_next = err_reg;
    if (cmd_valid_in) begin
      if (cmd_busy_in) begin
        err_next = ERR_BUSY;
      end else if (cmd_reserved_in) begin
        err_next = ERR_RESERVED;
      end else if (cmd_unsupported_in) begin
        err_next = ERR_UNSUPPORTED;
      end else begin
        err_next = ERR_OK;
      end
    end
  end

  // ---------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      term_chg_reg  <= 1'b0;
      over_temp_reg <= 1'b0;
      term_dsg_reg  <= 1'b0;
      rem_cap_reg   <= 1'b0;
      rem_time_reg  <= 1'b0;
      init_reg      <= 1'b0;
      dsg_reg       <= 1'b1;
      full_chg_reg  <= 1'b0;
      full_dsg_reg  <= 1'b0;
      perm_fail_reg <= 1'b0;
      eod2_reg      <= 1'b0;
      err_reg       <= ERR_OK;
      cycle_reg     <= 16'h0000;
      prev_cap_reg  <= 16'h0000;
      prev_tte_reg  <= 16'h0000;
    end else begin
      term_chg_reg  <= term_chg_next;
      over_temp_reg <= over_temp_next;
      term_dsg_reg  <= term_dsg_next;
      rem_cap_reg   <= rem_cap_next;
      rem_time_reg  <= rem_time_next;
      init_reg      <= init_next;
      dsg_reg       <= dsg_next;
      full_chg_reg  <= full_chg_next;
      full_dsg_reg  <= full_dsg_next;
      perm_fail_reg <= perm_fail_next;
      eod2_reg      <= eod2_next;
      err_reg       <= err_next;
      cycle_reg     <= cycle_next;
      if (update_in) begin
        prev_cap_reg <= rem_cap;
        prev_tte_reg <= tte;
      end
    end
  end

  // ---------------------------------------------------------------
  // status words
  // ---------------------------------------------------------------
  always_comb begin
    battery_status_out               = 16'h0000;
    battery_status_out[TERM_CHG_BIT] = term_chg_reg;
    battery_status_out[OVER_TEMP_BIT] = over_temp_reg;
    battery_status_out[TERM_DSG_BIT] = term_dsg_reg;
    battery_status_out[REM_CAP_BIT]  = rem_cap_reg;
    battery_status_out[REM_TIME_BIT] = rem_time_reg;
    battery_status_out[INIT_BIT]     = init_reg;
    battery_status_out[DSG_BIT]      = dsg_reg;
    battery_status_out[FULL_CHG_BIT] = full_chg_reg;
    battery_status_out[FULL_DSG_BIT] = full_dsg_reg;
    battery_status_out[3:0]          = err_reg;
  end

  always_comb begin
    pack_status_out               = 16'h0000;
    pack_status_out[EOD2_BIT]     = eod2_reg;
    pack_status_out[SEAL_BIT]     = sealed_in;
    pack_status_out[AFE_FAIL_BIT] = front_end_fail_in;
    pack_status_out[DQ_BIT]       = discharge_ok_in;
    pack_status_out[PERM_FAIL_BIT] = perm_fail_reg;
    pack_status_out[SEC_PROT_BIT] = sec_prot_fault_in;
    pack_status_out[CELL_UV_BIT]  = cell_uv_fault_in;
  end

  assign cycle_count_out = cycle_reg;

  // status word read for its command code
  assign read_valid_out = cmd_valid_in && (cmd_code_in == STATUS_CMD);
  assign read_data_out  = battery_status_out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  term_chg_set_a: assert property (update_in && charge_term_in
    |=> battery_status_out[TERM_CHG_BIT])
    else $error("terminate-charge not set");
  over_temp_set_a: assert property (update_in && ot_set
    |=> over_temp_reg)
    else $error("over-temp not set");
  over_temp_hold_a: assert property ($fell(over_temp_reg)
    |-> $past(update_in) && $past(ot_clr))
    else $error("over-temp cleared early");
  term_dsg_set_a: assert property (update_in && rem_cap == 16'h0000
    |=> term_dsg_reg)
    else $error("terminate-discharge not set");
  term_dsg_clr_a: assert property ($fell(term_dsg_reg)
    |-> $past(update_in) && $past(td_clr))
    else $error("terminate-discharge cleared early");
  cap_alarm_a: assert property (update_in && rc_set
    |=> rem_cap_reg)
    else $error("capacity alarm not set");
  dsg_flag_a: assert property (update_in && charging_in
    |=> !dsg_reg)
    else $error("discharging stays set while charging");
  full_dsg_clr_a: assert property (update_in && !fd_set
    && relative_soc_in >= 8'h14 |=> !full_dsg_reg)
    else $error("fully-discharged not cleared");
  busy_code_a: assert property (cmd_valid_in && cmd_busy_in
    |=> battery_status_out[3:0] == 4'h1)
    else $error("busy code missing");
  cycle_sat_a: assert property (cycle_reg == 16'hffff
    |=> cycle_reg == 16'hffff)
    else $error("cycle count wrapped");
  perm_fail_a: assert property (perm_fail_byte_in == 8'h66
    |=> pack_status_out[PERM_FAIL_BIT])
    else $error("permanent failure not set");

endmodule

// ==== verilog/batt_flags_pkg.sv ====
// Purpose: constants for the battery status and pack status flag logic
// Assumes: 16-bit measurement words, one clock
// Notes:   bit positions follow the battery status and pack status words
package batt_flags_pkg;

  // ---------------------------------------------------------------
  // battery status word layout
  // ---------------------------------------------------------------
  localparam int unsigned TERM_CHG_BIT   = 14;
  localparam int unsigned OVER_TEMP_BIT  = 12;
  localparam int unsigned TERM_DSG_BIT   = 11;
  localparam int unsigned REM_CAP_BIT    = 9;
  localparam int unsigned REM_TIME_BIT   = 8;
  localparam int unsigned INIT_BIT       = 7;
  localparam int unsigned DSG_BIT        = 6;
  localparam int unsigned FULL_CHG_BIT   = 5;
  localparam int unsigned FULL_DSG_BIT   = 4;
  localparam logic [7:0]  STATUS_CMD     = 8'h16;

  // ---------------------------------------------------------------
  // error codes
  // ---------------------------------------------------------------
  localparam logic [3:0] ERR_OK          = 4'h0;
  localparam logic [3:0] ERR_BUSY        = 4'h1;
  localparam logic [3:0] ERR_RESERVED    = 4'h2;
  localparam logic [3:0] ERR_UNSUPPORTED = 4'h3;

  // ---------------------------------------------------------------
  // pack status word layout
  // ---------------------------------------------------------------
  localparam int unsigned EOD2_BIT       = 0;
  localparam int unsigned SEAL_BIT       = 1;
  localparam int unsigned AFE_FAIL_BIT   = 2;
  localparam int unsigned DQ_BIT         = 3;
  localparam int unsigned PERM_FAIL_BIT  = 4;
  localparam int unsigned SEC_PROT_BIT   = 5;
  localparam int unsigned CELL_UV_BIT    = 6;

  // ---------------------------------------------------------------
  // fixed values
  // ---------------------------------------------------------------
  localparam logic [7:0]  PERM_FAIL_SET_CODE = 8'h66;
  localparam logic [7:0]  PERM_FAIL_CLR_CODE = 8'h00;
  localparam logic [15:0] CYCLE_MAX          = 16'hffff;
  localparam logic [7:0]  FULL_DSG_CLR       = 8'h14;
  localparam logic [15:0] STATUS_RST         = 16'h0040;

endpackage

// ==== bench/smbus_host_model.sv ====
// Purpose: host side model that issues function codes to the flag logic
// Assumes: request launched after a falling edge, answer taken at rising
// Notes:   released code lines show the inverse of the last code
`timescale 1ns/1ns
module smbus_host_model (
  // clock
  input  wire logic        clk_in,
  // request
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_code_out,
  output logic [2:0]       qual_out,
  // answer
  input  wire logic        read_valid_in,
  input  wire logic [15:0] read_data_in
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 8'h00;
    qual_out      = 3'h0;
  end

  // qual is busy, reserved, unsupported
  task automatic send(input logic [7:0] c, input logic [2:0] q,
                      output logic v, output logic [15:0] d);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out  = c;
    qual_out      = q;
    @(posedge clk_in);
    v = read_valid_in;
    d = read_data_in;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_code_out  = ~c;
    qual_out      = 3'h0;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the battery status flag logic
// Assumes: inputs change at falling edges, one update pulse per step
// Notes:   cycle count run walks the full 16-bit range
`timescale 1ns/1ns
module testbench
  import batt_flags_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_in, nrst_in, update_in, capacity_mode_in, charging_in;
  logic        use_cell_voltage_in, charge_term_in, overcharge_in;
  logic        config_valid_in, config_bad_in, sealed_in, front_end_fail_in;
  logic        discharge_ok_in, sec_prot_fault_in, cell_uv_fault_in;
  logic        cycle_inc_in, cmd_v, rv;
  logic [15:0] voltage_in, cell_voltage_in, current_in, temperature_in;
  logic [15:0] remaining_capacity_ma_in, remaining_capacity_mw_in;
  logic [15:0] time_to_empty_ma_in, time_to_empty_mw_in;
  logic [15:0] ot_charge_in, ot_charge_reset_in, ot_dsg_in, ot_dsg_reset_in;
  logic [15:0] terminate_voltage_in, suspend_temp_low_in, cap_alarm_in;
  logic [15:0] time_alarm_in, end_of_discharge_level2_in, overload_current_in;
  logic [15:0] st, ps, cc, rdat;
  logic [7:0]  relative_soc_in, full_clear_pct_in, battery_low_pct_in;
  logic [7:0]  perm_fail_byte_in, code;
  logic [2:0]  qual;
  int          fail_count, checks_done;
  localparam logic [2:0] QV [5] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b110};
  localparam logic [3:0] EV [5] = '{ERR_OK, ERR_BUSY, ERR_RESERVED,
                                    ERR_UNSUPPORTED, ERR_BUSY};

  battery_status_flag_logic u_battery_status_flag_logic (
    .clk_in, .nrst_in, .update_in, .capacity_mode_in, .voltage_in,
    .cell_voltage_in, .use_cell_voltage_in, .current_in, .charging_in,
    .temperature_in, .remaining_capacity_ma_in, .remaining_capacity_mw_in,
    .time_to_empty_ma_in, .time_to_empty_mw_in, .relative_soc_in,
    .charge_term_in, .overcharge_in, .ot_charge_in, .ot_charge_reset_in,
    .ot_dsg_in, .ot_dsg_reset_in, .terminate_voltage_in,
    .suspend_temp_low_in, .cap_alarm_in, .time_alarm_in,
    .end_of_discharge_level2_in, .overload_current_in, .full_clear_pct_in,
    .battery_low_pct_in, .config_valid_in, .config_bad_in, .sealed_in,
    .front_end_fail_in, .discharge_ok_in, .perm_fail_byte_in,
    .sec_prot_fault_in,
    .cell_uv_fault_in, .cycle_inc_in, .cmd_valid_in(cmd_v),
    .cmd_code_in(code), .cmd_busy_in(qual[2]), .cmd_reserved_in(qual[1]),
    .cmd_unsupported_in(qual[0]), .battery_status_out(st),
    .pack_status_out(ps), .cycle_count_out(cc), .read_data_out(rdat),
    .read_valid_out(rv)
  );
  smbus_host_model host (.clk_in, .cmd_valid_out(cmd_v), .cmd_code_out(code),
    .qual_out(qual), .read_valid_in(rv), .read_data_in(rdat));

  always #5 clk_in = ~clk_in;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk_w(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_b(string n, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic upd;
    update_in = 1'b1;
    @(negedge clk_in);
    update_in = 1'b0;
    @(negedge clk_in);
  endtask

  task automatic nominal;
    voltage_in = 16'h1000;
    cell_voltage_in = 16'h1000;
    current_in = 16'h0064;
    temperature_in = 16'h0100;
    remaining_capacity_ma_in = 16'h03e8;
    remaining_capacity_mw_in = 16'h03e8;
    time_to_empty_ma_in = 16'h0258;
    time_to_empty_mw_in = 16'h0258;
    relative_soc_in = 8'h32;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  task automatic t_err;
    logic        v;
    logic [15:0] d;
    logic [3:0]  pe;
    pe = ERR_OK;
    for (int i = 0; i < 5; i++) begin
      host.send(STATUS_CMD, QV[i], v, d);
      chk_b("read valid", 1'b1, v);
      chk_w("read word", {STATUS_RST[15:4], pe}, d);
      chk_w("err", 16'(EV[i]), 16'(st[3:0]));
      pe = EV[i];
    end
    host.send(8'h17, 3'h0, v, d);
    chk_b("read valid", 1'b0, v);
    $display("done error codes");
  endtask

  task automatic t_term;
    relative_soc_in = 8'h5f;
    charging_in = 1'b1;
    charge_term_in = 1'b1;
    upd;
    chk_b("term chg", 1'b1, st[TERM_CHG_BIT]);
    chk_b("full chg", 1'b1, st[FULL_CHG_BIT]);
    chk_b("dsg", 1'b0, st[DSG_BIT]);
    charge_term_in = 1'b0;
    upd;
    chk_b("term chg", 1'b1, st[TERM_CHG_BIT]);
    charging_in = 1'b0;
    upd;
    chk_b("term chg", 1'b0, st[TERM_CHG_BIT]);
    chk_b("dsg", 1'b1, st[DSG_BIT]);
    relative_soc_in = 8'h5a;
    upd;
    chk_b("full chg", 1'b1, st[FULL_CHG_BIT]);
    relative_soc_in = 8'h59;
    upd;
    chk_b("full chg", 1'b0, st[FULL_CHG_BIT]);
    overcharge_in = 1'b1;
    upd;
    chk_b("full chg", 1'b1, st[FULL_CHG_BIT]);
    overcharge_in = 1'b0;
    nominal;
    $display("done charge termination");
  endtask

  task automatic t_temp;
    charging_in = 1'b1;
    temperature_in = 16'h0200;
    upd;
    chk_b("over temp", 1'b1, st[OVER_TEMP_BIT]);
    temperature_in = 16'h01c0;
    upd;
    chk_b("over temp", 1'b1, st[OVER_TEMP_BIT]);
    temperature_in = 16'h01bf;
    upd;
    chk_b("over temp", 1'b0, st[OVER_TEMP_BIT]);
    charging_in = 1'b0;
    temperature_in = 16'h0300;
    upd;
    chk_b("over temp", 1'b1, st[OVER_TEMP_BIT]);
    temperature_in = 16'h02bf;
    upd;
    chk_b("over temp", 1'b0, st[OVER_TEMP_BIT]);
    nominal;
    $display("done over temperature");
  endtask

  task automatic t_dsg;
    remaining_capacity_ma_in = 16'h0000;
    upd;
    chk_b("term dsg", 1'b1, st[TERM_DSG_BIT]);
    chk_b("cap alarm", 1'b1, st[REM_CAP_BIT]);
    nominal;
    upd;
    chk_b("term dsg", 1'b0, st[TERM_DSG_BIT]);
    chk_b("cap alarm", 1'b0, st[REM_CAP_BIT]);
    voltage_in = terminate_voltage_in;
    upd;
    chk_b("term dsg", 1'b1, st[TERM_DSG_BIT]);
    chk_b("level2", 1'b1, ps[EOD2_BIT]);
    chk_b("full dsg", 1'b1, st[FULL_DSG_BIT]);
    nominal;
    upd;
    chk_b("level2", 1'b0, ps[EOD2_BIT]);
    temperature_in = suspend_temp_low_in;
    repeat (2) @(negedge clk_in);
    chk_b("term dsg idle", 1'b0, st[TERM_DSG_BIT]);
    upd;
    chk_b("term dsg", 1'b1, st[TERM_DSG_BIT]);
    nominal;
    cell_uv_fault_in = 1'b1;
    upd;
    chk_b("term dsg", 1'b1, st[TERM_DSG_BIT]);
    chk_b("cell uv", 1'b1, ps[CELL_UV_BIT]);
    cell_uv_fault_in = 1'b0;
    upd;
    chk_b("term dsg", 1'b0, st[TERM_DSG_BIT]);
    $display("done terminate discharge");
  endtask

  task automatic t_full;
    use_cell_voltage_in = 1'b1;
    cell_voltage_in = 16'h0d00;
    upd;
    chk_b("level2", 1'b1, ps[EOD2_BIT]);
    current_in = 16'h1000;
    cell_voltage_in = 16'h0cff;
    upd;
    chk_b("full dsg", 1'b0, st[FULL_DSG_BIT]);
    current_in = 16'h0064;
    relative_soc_in = 8'h13;
    upd;
    chk_b("full dsg", 1'b1, st[FULL_DSG_BIT]);
    cell_voltage_in = 16'h1000;
    upd;
    chk_b("full dsg", 1'b1, st[FULL_DSG_BIT]);
    relative_soc_in = 8'h14;
    upd;
    chk_b("full dsg", 1'b0, st[FULL_DSG_BIT]);
    relative_soc_in = 8'h06;
    upd;
    chk_b("full dsg", 1'b1, st[FULL_DSG_BIT]);
    use_cell_voltage_in = 1'b0;
    nominal;
    $display("done fully discharged");
  endtask

  task automatic t_alarm;
    capacity_mode_in = 1'b1;
    remaining_capacity_mw_in = 16'h0032;
    upd;
    chk_b("cap alarm", 1'b1, st[REM_CAP_BIT]);
    capacity_mode_in = 1'b0;
    upd;
    chk_b("cap alarm", 1'b0, st[REM_CAP_BIT]);
    time_to_empty_ma_in = 16'h0005;
    upd;
    chk_b("time alarm", 1'b1, st[REM_TIME_BIT]);
    capacity_mode_in = 1'b1;
    upd;
    chk_b("time alarm", 1'b0, st[REM_TIME_BIT]);
    capacity_mode_in = 1'b0;
    nominal;
    $display("done alarms");
  endtask

  task automatic t_pack;
    config_valid_in = 1'b1;
    @(negedge clk_in);
    config_valid_in = 1'b0;
    @(negedge clk_in);
    chk_b("init", 1'b1, st[INIT_BIT]);
    config_bad_in = 1'b1;
    @(negedge clk_in);
    config_bad_in = 1'b0;
    @(negedge clk_in);
    chk_b("init", 1'b0, st[INIT_BIT]);
    sealed_in = 1'b1;
    discharge_ok_in = 1'b1;
    sec_prot_fault_in = 1'b1;
    @(negedge clk_in);
    chk_w("pack", 16'h002a, ps & 16'h006e);
    {sealed_in, discharge_ok_in, sec_prot_fault_in} = 3'b000;
    {front_end_fail_in, cell_uv_fault_in} = 2'b11;
    @(negedge clk_in);
    chk_w("pack", 16'h0044, ps & 16'h006e);
    {front_end_fail_in, cell_uv_fault_in} = 2'b00;
    perm_fail_byte_in = PERM_FAIL_SET_CODE;
    repeat (2) @(negedge clk_in);
    chk_b("perm fail", 1'b1, ps[PERM_FAIL_BIT]);
    perm_fail_byte_in = 8'h12;
    repeat (2) @(negedge clk_in);
    chk_b("perm fail", 1'b1, ps[PERM_FAIL_BIT]);
    perm_fail_byte_in = PERM_FAIL_CLR_CODE;
    repeat (2) @(negedge clk_in);
    chk_b("perm fail", 1'b0, ps[PERM_FAIL_BIT]);
    $display("done pack status");
  endtask

  task automatic t_cycle;
    cycle_inc_in = 1'b1;
    repeat (65534) @(negedge clk_in);
    chk_w("cycles", 16'hfffe, cc);
    repeat (4) @(negedge clk_in);
    cycle_inc_in = 1'b0;
    chk_w("cycles", CYCLE_MAX, cc);
    $display("done cycle count");
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {clk_in, nrst_in, update_in, capacity_mode_in, charging_in} = 5'h00;
    {use_cell_voltage_in, charge_term_in, overcharge_in} = 3'h0;
    {config_valid_in, config_bad_in, sealed_in, front_end_fail_in} = 4'h0;
    {discharge_ok_in, sec_prot_fault_in, cell_uv_fault_in} = 3'h0;
    {cycle_inc_in, perm_fail_byte_in} = 9'h000;
    fail_count = 0;
    checks_done = 0;
    nominal;
    {ot_charge_in, ot_charge_reset_in} = {16'h0200, 16'h01c0};
    {ot_dsg_in, ot_dsg_reset_in} = {16'h0300, 16'h02c0};
    {terminate_voltage_in, suspend_temp_low_in} = {16'h0c00, 16'h0010};
    {cap_alarm_in, time_alarm_in} = {16'h0064, 16'h000a};
    {end_of_discharge_level2_in, overload_current_in} = {16'h0d00, 16'h1000};
    {full_clear_pct_in, battery_low_pct_in} = {8'h5a, 8'h07};
    repeat (16) @(negedge clk_in);
    chk_w("reset status", STATUS_RST, st);
    chk_w("reset cycles", 16'h0000, cc);
    nrst_in = 1'b1;
    @(negedge clk_in);
    t_err;
    t_term;
    t_temp;
    t_dsg;
    t_full;
    t_alarm;
    t_pack;
    t_cycle;
    results;
  end

  initial begin
    #1000000;
    fail_count++;
    results;
  end
endmodule
